// ==== hdl/pcc_regs.vh ====
// constants for the protection configuration and control register bank
`ifndef PCC_REGS_VH
`define PCC_REGS_VH

// ----------------------------------------------------------------
// command codes on the decoded command port
// ----------------------------------------------------------------
`define PCC_CMD_CONFIG_WRITE 2'h0
`define PCC_CMD_WRITE_LATCH_SET 2'h1
`define PCC_CMD_ARRAY_WRITE 2'h2
`define PCC_CMD_CONTROL_WRITE 2'h3

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define PCC_CFG_OVERCHARGE_LO 14
`define PCC_CFG_UNDERVOLT_LO 12
`define PCC_CFG_OVERCURRENT_LO 10
`define PCC_CFG_CHARGE_PERMIT_LO 8
`define PCC_CFG_CELL_COUNT 7
`define PCC_CFG_BLOCK_OFF 6
`define PCC_CFG_SHADOW_INIT 16'h30c0

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PCC_CTL_SLEEP 7
`define PCC_CTL_GAIN_LO 8
`define PCC_CTL_CHARGE_SW 10
`define PCC_CTL_DISCHARGE_SW 11
`define PCC_CTL_BALANCE_LO 12
`define PCC_CTL_RESET 16'h0000

// ----------------------------------------------------------------
// decoded threshold and gain values
// ----------------------------------------------------------------
`define PCC_OC_MV_0 13'h004b
`define PCC_OC_MV_1 13'h0064
`define PCC_OC_MV_2 13'h007d
`define PCC_OC_MV_3 13'h0096
`define PCC_CE_MV_0 13'h01f4
`define PCC_CE_MV_1 13'h0320
`define PCC_CE_MV_2 13'h044c
`define PCC_CE_MV_3 13'h0578
`define PCC_OV_MV_0 13'h1068
`define PCC_OV_MV_1 13'h109a
`define PCC_OV_MV_2 13'h10cc
`define PCC_OV_MV_3 13'h10fe
`define PCC_GAIN_0 13'h000a
`define PCC_GAIN_1 13'h0019
`define PCC_GAIN_2 13'h0050
`define PCC_GAIN_3 13'h00a0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCC_STORE_CYCLES 16

`endif

// ==== hdl/pcc_shadow_mem.v ====
// shadow nonvolatile word behind the configuration sram
`timescale 1ns/10ps
module pcc_shadow_mem #(
   parameter WIDTH = 16,
   parameter [15:0] INIT = 16'h30c0
) (
   // clock
   input wire clk,
   // write side
   input wire wr_en,
   input wire [WIDTH-1:0] wr_data,
   // read side, registered
   output reg [WIDTH-1:0] rd_data
);

   // ----------------------------------------------------------------
   // storage, survives the bank reset like a nonvolatile cell
   // ----------------------------------------------------------------
   reg [WIDTH-1:0] cells; // shadow bits

   initial begin
      cells = INIT[WIDTH-1:0];
      rd_data = INIT[WIDTH-1:0];
   end

   // store and registered read
   always @(posedge clk) begin
      if (wr_en) begin
         cells <= wr_data;
      end
      rd_data <= cells;
   end

endmodule // pcc_shadow_mem

// ==== hdl/pcc_top.v ====
// protection configuration and volatile control register bank
// Functional notes
// - over-current field selects 75 to 150 mV
// - block-off bit zero keeps low-cell blocking on
// - charge-permit field selects 0.5 to 1.4 V
// - cell-count bit: one four cells, zero three
// - shadow recalled into config sram at power-up
// - config write updates sram copy only
// - latch-set then array write stores shadow
// - store ignores array address and data
// - unstored changes lost over power cycle
// - control register volatile, written by control write
// - control cleared at power-up and sleep exit
// - low five bits ignored, bits five six reserved
// - sleep bit enters sleep below supply limit
// - gain bits select x10 x25 x80 x160
// - charge bit one drives pin low
// - discharge bit one drives pin low
// - bits 12 to 15 drive balance pins
// - switch pins hold during protection mode
// - configuration register field layout
// - over-charge field selects 4.20 to 4.35 V
`timescale 1ns/10ps
`include "pcc_regs.vh"
module pcc_top #(
   parameter STORE_CYCLES = `PCC_STORE_CYCLES,
   parameter [15:0] SHADOW_INIT = `PCC_CFG_SHADOW_INIT,
   parameter BALANCE_PINS = 4
) (
   // clock and reset
   input wire clk,
   input wire srst,
   // decoded command port from the serial front end
   input wire cmd_valid,
   input wire [1:0] cmd_code,
   input wire [15:0] cmd_data,
   output reg cmd_ready,
   // supply and protection state from the analog side
   input wire supply_below_sleep_limit,
   input wire wake_event,
   input wire charge_prot_active,
   input wire discharge_prot_active,
   // configuration readback and store progress
   output reg [15:0] config_rdata,
   output reg store_busy,
   output reg write_latch,
   // decoded configuration
   output reg overcharge_level_sel_hi,
   output reg overcharge_level_sel_lo,
   output reg undervoltage_level_sel_hi,
   output reg undervoltage_level_sel_lo,
   output reg overcurrent_level_sel_hi,
   output reg overcurrent_level_sel_lo,
   output reg charge_permit_level_sel_hi,
   output reg charge_permit_level_sel_lo,
   output reg cell_count_sel,
   output reg low_cell_block_en,
   output reg [12:0] overcharge_level_mv,
   output reg [12:0] overcurrent_level_mv,
   output reg [12:0] charge_permit_level_mv,
   // decoded control
   output reg sleep_active,
   output reg sense_gain_sel_hi,
   output reg sense_gain_sel_lo,
   output reg [12:0] sense_gain,
   output reg charge_switch_pin,
   output reg discharge_switch_pin,
   output reg [BALANCE_PINS-1:0] balance_pin
);

   // ----------------------------------------------------------------
   // constants and state codes
   // ----------------------------------------------------------------
   localparam [1:0] ST_RECALL_RD = 2'h0; // wait for shadow read data
   localparam [1:0] ST_RECALL_LD = 2'h1; // copy shadow into sram
   localparam [1:0] ST_RUN = 2'h2; // normal command service
   localparam [1:0] ST_STORE = 2'h3; // nonvolatile store cycle
   localparam [31:0] STORE_END = STORE_CYCLES - 1; // last count of a store, full width
   localparam [15:0] STORE_LAST = STORE_END[15:0]; // last count cut to the counter width

   // four-way lookup used by every threshold and gain decode
   function [12:0] pick4;
      input [1:0] sel;
      input [12:0] v0;
      input [12:0] v1;
      input [12:0] v2;
      input [12:0] v3;
      begin
         case (sel)
            2'h0: pick4 = v0;
            2'h1: pick4 = v1;
            2'h2: pick4 = v2;
            default: pick4 = v3;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // internal state
   // ----------------------------------------------------------------
   reg [1:0] state; // sequencer state
   reg [15:0] config_sram; // working configuration copy
   reg [15:0] control; // volatile control bytes
   reg [15:0] store_count; // cycles spent in a store
   reg shadow_we; // write strobe to shadow store
   wire [15:0] shadow_rd; // registered shadow read data
   wire cmd_take; // command accepted this edge
   wire [1:0] oc_sel; // over-current field
   wire [1:0] ce_sel; // charge-permit field
   wire [1:0] ov_sel; // over-charge field
   wire [1:0] gain_sel; // sense gain field

   assign cmd_take = cmd_valid && cmd_ready;
   assign oc_sel = config_sram[`PCC_CFG_OVERCURRENT_LO+1:`PCC_CFG_OVERCURRENT_LO];
   assign ce_sel = config_sram[`PCC_CFG_CHARGE_PERMIT_LO+1:`PCC_CFG_CHARGE_PERMIT_LO];
   assign ov_sel = config_sram[`PCC_CFG_OVERCHARGE_LO+1:`PCC_CFG_OVERCHARGE_LO];
   assign gain_sel = control[`PCC_CTL_GAIN_LO+1:`PCC_CTL_GAIN_LO];

   // ----------------------------------------------------------------
   // shadow nonvolatile store
   // ----------------------------------------------------------------
   // the shadow keeps its bits across srst, so a change never stored
   // comes back as the old value after a power cycle
   pcc_shadow_mem #(
      .WIDTH(16),
      .INIT(SHADOW_INIT)
   ) u_shadow (
      .clk(clk),
      .wr_en(shadow_we),
      .wr_data(config_sram),
      .rd_data(shadow_rd)
   );

   // ----------------------------------------------------------------
   // sequencer: recall, command service, store cycle
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         state <= ST_RECALL_RD;
         config_sram <= 16'h0000;
         store_count <= 16'h0000;
         shadow_we <= 1'b0;
         write_latch <= 1'b0;
         store_busy <= 1'b0;
         cmd_ready <= 1'b0;
      end else begin
         shadow_we <= 1'b0;
         case (state)
            // shadow read data settles one edge after release
            ST_RECALL_RD: begin
               state <= ST_RECALL_LD;
            end
            // automatic recall at power-up
            ST_RECALL_LD: begin
               config_sram <= shadow_rd;
               cmd_ready <= 1'b1;
               state <= ST_RUN;
            end
            // command service
            ST_RUN: begin
               if (cmd_take) begin
                  if (cmd_code == `PCC_CMD_CONFIG_WRITE) begin
                     // sram copy only, shadow left alone
                     config_sram <= cmd_data;
                  end else if (cmd_code == `PCC_CMD_WRITE_LATCH_SET) begin
                     write_latch <= 1'b1;
                  end else if (cmd_code == `PCC_CMD_ARRAY_WRITE) begin
                     // any address and data starts the store
                     if (write_latch) begin
                        shadow_we <= 1'b1;
                        store_busy <= 1'b1;
                        cmd_ready <= 1'b0;
                        store_count <= 16'h0000;
                        state <= ST_STORE;
                     end
                     write_latch <= 1'b0;
                  end
               end
            end
            // nonvolatile cycle, commands held off
            default: begin
               if (store_count == STORE_LAST) begin
                  store_busy <= 1'b0;
                  cmd_ready <= 1'b1;
                  state <= ST_RUN;
               end else begin
                  store_count <= store_count + 16'h0001;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // volatile control register and sleep state
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         control <= `PCC_CTL_RESET;
         sleep_active <= 1'b0;
      end else if (sleep_active) begin
         // leaving sleep clears both control bytes
         if (wake_event) begin
            sleep_active <= 1'b0;
            control <= `PCC_CTL_RESET;
         end
      end else begin
         // only the control write touches it
         if (cmd_take && cmd_code == `PCC_CMD_CONTROL_WRITE) begin
            // low five bits are don't-care, bits five and six kept zero
            control <= {cmd_data[15:7], 7'h00};
         end
         // sleep only while supply is under the limit
         if (control[`PCC_CTL_SLEEP] && supply_below_sleep_limit) begin
            sleep_active <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration decode, all registered
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         config_rdata <= 16'h0000;
         overcharge_level_sel_hi <= 1'b0;
         overcharge_level_sel_lo <= 1'b0;
         undervoltage_level_sel_hi <= 1'b0;
         undervoltage_level_sel_lo <= 1'b0;
         overcurrent_level_sel_hi <= 1'b0;
         overcurrent_level_sel_lo <= 1'b0;
         charge_permit_level_sel_hi <= 1'b0;
         charge_permit_level_sel_lo <= 1'b0;
         cell_count_sel <= 1'b0;
         low_cell_block_en <= 1'b1;
         overcharge_level_mv <= `PCC_OV_MV_0;
         overcurrent_level_mv <= `PCC_OC_MV_0;
         charge_permit_level_mv <= `PCC_CE_MV_0;
      end else begin
         config_rdata <= config_sram;
         // field layout
         overcharge_level_sel_hi <= config_sram[`PCC_CFG_OVERCHARGE_LO+1];
         overcharge_level_sel_lo <= config_sram[`PCC_CFG_OVERCHARGE_LO];
         undervoltage_level_sel_hi <= config_sram[`PCC_CFG_UNDERVOLT_LO+1];
         undervoltage_level_sel_lo <= config_sram[`PCC_CFG_UNDERVOLT_LO];
         overcurrent_level_sel_hi <= oc_sel[1];
         overcurrent_level_sel_lo <= oc_sel[0];
         charge_permit_level_sel_hi <= ce_sel[1];
         charge_permit_level_sel_lo <= ce_sel[0];
         // one means four cells, zero three
         cell_count_sel <= config_sram[`PCC_CFG_CELL_COUNT];
         // blocking is on while the bit is zero
         low_cell_block_en <= ~config_sram[`PCC_CFG_BLOCK_OFF];
         // over-charge level per cell
         overcharge_level_mv <= pick4(ov_sel, `PCC_OV_MV_0, `PCC_OV_MV_1,
            `PCC_OV_MV_2, `PCC_OV_MV_3);
         // pack over-current level
         overcurrent_level_mv <= pick4(oc_sel, `PCC_OC_MV_0, `PCC_OC_MV_1,
            `PCC_OC_MV_2, `PCC_OC_MV_3);
         // too-low cell level
         charge_permit_level_mv <= pick4(ce_sel, `PCC_CE_MV_0, `PCC_CE_MV_1,
            `PCC_CE_MV_2, `PCC_CE_MV_3);
      end
   end

   // ----------------------------------------------------------------
   // control decode and pin drive
   // ----------------------------------------------------------------
   // pins take the control value one edge after the write
   always @(posedge clk) begin
      if (srst) begin
         sense_gain_sel_hi <= 1'b0;
         sense_gain_sel_lo <= 1'b0;
         sense_gain <= `PCC_GAIN_0;
         charge_switch_pin <= 1'b1;
         discharge_switch_pin <= 1'b1;
      end else begin
         sense_gain_sel_hi <= gain_sel[1];
         sense_gain_sel_lo <= gain_sel[0];
         // amplifier gain
         sense_gain <= pick4(gain_sel, `PCC_GAIN_0, `PCC_GAIN_1,
            `PCC_GAIN_2, `PCC_GAIN_3);
         // held while in protection, bit one drives low
         if (!charge_prot_active) begin
            charge_switch_pin <= ~control[`PCC_CTL_CHARGE_SW];
         end
         // same for the discharge switch
         if (!discharge_prot_active) begin
            discharge_switch_pin <= ~control[`PCC_CTL_DISCHARGE_SW];
         end
      end
   end

   // one balance pin per control bit, high when set
   genvar gi;
   generate
      for (gi = 0; gi < BALANCE_PINS; gi = gi + 1) begin : g_bal
         always @(posedge clk) begin
            if (srst) begin
               balance_pin[gi] <= 1'b0;
            end else begin
               balance_pin[gi] <= control[`PCC_CTL_BALANCE_LO+gi];
            end
         end
      end
   endgenerate

endmodule // pcc_top

// ==== test/pcc_chk_sva.sv ====
// assertion checker for the protection config and control bank
`timescale 1ns/10ps
module pcc_chk #(
   parameter STORE_CYCLES = 16
) (
   // clock and reset
   input wire clk,
   input wire srst,
   // command port
   input wire cmd_valid,
   input wire [1:0] cmd_code,
   input wire [15:0] cmd_data,
   input wire cmd_ready,
   // analog side
   input wire supply_below_sleep_limit,
   input wire wake_event,
   input wire charge_prot_active,
   input wire discharge_prot_active,
   // observed outputs
   input wire [15:0] config_rdata,
   input wire store_busy,
   input wire write_latch,
   input wire overcharge_level_sel_hi,
   input wire overcharge_level_sel_lo,
   input wire undervoltage_level_sel_hi,
   input wire undervoltage_level_sel_lo,
   input wire overcurrent_level_sel_hi,
   input wire overcurrent_level_sel_lo,
   input wire charge_permit_level_sel_hi,
   input wire charge_permit_level_sel_lo,
   input wire cell_count_sel,
   input wire sense_gain_sel_hi,
   input wire sense_gain_sel_lo,
   input wire [12:0] overcharge_level_mv,
   input wire [12:0] overcurrent_level_mv,
   input wire [12:0] charge_permit_level_mv,
   input wire low_cell_block_en,
   input wire sleep_active,
   input wire [12:0] sense_gain,
   input wire charge_switch_pin,
   input wire discharge_switch_pin,
   input wire [3:0] balance_pin
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   localparam int SB = STORE_CYCLES + 3;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // picks one of four table values by a two-bit code
   function automatic logic [12:0] pk(input logic [1:0] s, input logic [12:0] a, b, c, d);
      return s[1] ? (s[0] ? d : c) : (s[0] ? b : a);
   endfunction
   wire take = cmd_valid && cmd_ready;
   // ----------------------------------------
   // properties
   // ----------------------------------------
   // control write taken while awake, no wake just after
   sequence s_ctl;
      take && cmd_code == 2'h3 && !sleep_active ##1 !wake_event;
   endsequence
   // latch set, then array write with the latch up
   sequence s_store;
      take && cmd_code == 2'h1 ##[1:4] take && cmd_code == 2'h2 && write_latch;
   endsequence
   property p_chg;
      s_ctl ##0 !charge_prot_active |-> ##1 charge_switch_pin == !$past(cmd_data[10], 2);
   endproperty
   property p_bal;
      s_ctl |-> ##1 balance_pin == $past(cmd_data[15:12], 2)
         && sense_gain == pk($past(cmd_data[9:8], 2), 13'h000a, 13'h0019, 13'h0050, 13'h00a0);
   endproperty
   property p_hold;
      !$past(srst) && $past(charge_prot_active) |-> $stable(charge_switch_pin);
   endproperty
   property p_cfg;
      take && cmd_code == 2'h0 |-> ##2 config_rdata == $past(cmd_data, 2);
   endproperty
   property p_map;
      overcurrent_level_mv == pk(config_rdata[11:10], 13'h004b, 13'h0064, 13'h007d, 13'h0096)
         && charge_permit_level_mv == pk(config_rdata[9:8], 13'h01f4, 13'h0320, 13'h044c, 13'h0578)
         && low_cell_block_en == !config_rdata[6];
   endproperty
   property p_store;
      s_store |-> ##1 store_busy && !cmd_ready ##[1:SB] !store_busy && cmd_ready;
   endproperty
   property p_latch;
      take && cmd_code == 2'h2 |=> !write_latch;
   endproperty
   property p_sleep;
      take && cmd_code == 2'h3 && cmd_data[7] && !sleep_active ##1 supply_below_sleep_limit && !wake_event
         |-> ##1 sleep_active;
   endproperty
   property p_wake;
      sleep_active && wake_event |=> !sleep_active ##1 balance_pin == 4'h0 && sense_gain == 13'h000a;
   endproperty
   // raw select bits and over-charge level follow the readback, gain follows its selects
   property p_sel;
      {overcharge_level_sel_hi, overcharge_level_sel_lo, undervoltage_level_sel_hi, undervoltage_level_sel_lo,
         overcurrent_level_sel_hi, overcurrent_level_sel_lo, charge_permit_level_sel_hi,
         charge_permit_level_sel_lo, cell_count_sel} == config_rdata[15:7]
         && overcharge_level_mv == pk(config_rdata[15:14], 13'h1068, 13'h109a, 13'h10cc, 13'h10fe)
         && sense_gain == pk({sense_gain_sel_hi, sense_gain_sel_lo}, 13'h000a, 13'h0019, 13'h0050, 13'h00a0);
   endproperty
   // discharge pin frozen while its protection mode is active
   property p_dhold;
      !$past(srst) && $past(discharge_prot_active) |-> $stable(discharge_switch_pin);
   endproperty
   a_chg: assert property (p_chg) else $error("charge pin wrong after control write");
   a_bal: assert property (p_bal) else $error("balance or gain wrong after write");
   a_hold: assert property (p_hold) else $error("charge pin moved in protection");
   a_cfg: assert property (p_cfg) else $error("config readback wrong");
   a_map: assert property (p_map) else $error("config decode wrong");
   a_store: assert property (p_store) else $error("store cycle wrong");
   a_latch: assert property (p_latch) else $error("latch not cleared");
   a_sleep: assert property (p_sleep) else $error("sleep not entered");
   a_wake: assert property (p_wake) else $error("control not cleared on wake");
   a_sel: assert property (p_sel) else $error("select bits or level decode wrong");
   a_dhold: assert property (p_dhold) else $error("discharge pin moved in protection");
endmodule // pcc_chk
bind pcc_top pcc_chk #(.STORE_CYCLES(STORE_CYCLES)) u_chk (.*);

// ==== test/pcc_host.sv ====
// pack microcontroller model issuing decoded register commands
`timescale 1ns/10ps
module pcc_host (
   // clock
   input wire clk,
   // command port
   input wire cmd_ready,
   output logic cmd_valid,
   output logic [1:0] cmd_code,
   output logic [15:0] cmd_data
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 2'h0;
      cmd_data = 16'h0000;
   end
   // holds the request until an edge that sees ready high
   task automatic send(input logic [1:0] c, input logic [15:0] d);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_data = (c == 2'h3) ? {d[15:7], 2'b00, d[4:0]} : d;
      // a ready that never rises is caught by the bench's cycle ceiling
      while (!cmd_ready) begin
         @(negedge clk);
      end
      @(posedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_code = ~c;
      cmd_data = ~cmd_data;
   endtask
   // persistence: latch set, then an array write of arbitrary data
   task automatic store(input logic [15:0] junk);
      send(2'h1, junk);
      send(2'h2, ~junk);
   endtask
endmodule // pcc_host

// ==== test/tb.sv ====
// self-checking bench for the protection config and control bank
`timescale 1ns/10ps
module tb;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk, srst, supply_below_sleep_limit, wake_event, charge_prot_active, discharge_prot_active;
   wire cmd_valid, cmd_ready, store_busy, write_latch, cell_count_sel, low_cell_block_en, sleep_active;
   wire charge_switch_pin, discharge_switch_pin;
   wire [1:0] cmd_code;
   wire [15:0] cmd_data, config_rdata;
   wire [12:0] overcharge_level_mv, overcurrent_level_mv, charge_permit_level_mv, sense_gain;
   wire [3:0] balance_pin;
   int bad_count, n_checks, cyc;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %h seen %h", n, e, g); end end
   pcc_top #(.STORE_CYCLES(2)) dut (.*, .overcharge_level_sel_hi(), .overcharge_level_sel_lo(),
      .undervoltage_level_sel_hi(), .undervoltage_level_sel_lo(), .overcurrent_level_sel_hi(),
      .overcurrent_level_sel_lo(), .charge_permit_level_sel_hi(), .charge_permit_level_sel_lo(),
      .sense_gain_sel_hi(), .sense_gain_sel_lo());
   pcc_host host (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         summarize();
      end
   end
   function automatic logic [12:0] pk(input logic [1:0] s, input logic [12:0] a, b, c, d);
      return s[1] ? (s[0] ? d : c) : (s[0] ? b : a);
   endfunction
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task w(input int n);
      repeat (n) @(negedge clk);
   endtask
   // power cycle: the shadow word survives, sram and control do not
   task pwr(input int n);
      srst = 1'b1;
      w(n);
      srst = 1'b0;
      w(4);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_boot;
      `CHK("cfg", 16'h30c0, config_rdata)
      `CHK("chg_pin", 1'b1, charge_switch_pin)
      `CHK("dis_pin", 1'b1, discharge_switch_pin)
      `CHK("bal", 4'h0, balance_pin)
      `CHK("gain", 13'h000a, sense_gain)
      `CHK("oc", 13'h004b, overcurrent_level_mv)
      `CHK("blk", 1'b0, low_cell_block_en)
      `CHK("cells", 1'b1, cell_count_sel)
      $display("t_boot done");
   endtask
   task t_cfg;
      logic [15:0] d;
      for (int i = 0; i < 4; i++) begin
         d = {i[1:0], i[1:0], i[1:0], i[1:0], i[0], i[1], 6'h2a};
         host.send(2'h0, d);
         w(3);
         `CHK("cfg", d, config_rdata)
         `CHK("oc", pk(i[1:0], 13'h004b, 13'h0064, 13'h007d, 13'h0096), overcurrent_level_mv)
         `CHK("ce", pk(i[1:0], 13'h01f4, 13'h0320, 13'h044c, 13'h0578), charge_permit_level_mv)
         `CHK("ov", pk(i[1:0], 13'h1068, 13'h109a, 13'h10cc, 13'h10fe), overcharge_level_mv)
         `CHK("blk", !i[1], low_cell_block_en)
         `CHK("cells", i[0], cell_count_sel)
      end
      $display("t_cfg done");
   endtask
   task t_ctl;
      logic [15:0] d;
      supply_below_sleep_limit = 1'b1;
      for (int i = 0; i < 4; i++) begin
         d = {4'h1 << i, i[1:0], i[1:0], 8'h1f};
         host.send(2'h3, d);
         w(3);
         `CHK("bal", 4'h1 << i, balance_pin)
         `CHK("chg_pin", !i[0], charge_switch_pin)
         `CHK("dis_pin", !i[1], discharge_switch_pin)
         `CHK("gain", pk(i[1:0], 13'h000a, 13'h0019, 13'h0050, 13'h00a0), sense_gain)
         `CHK("sleep", 1'b0, sleep_active)
      end
      supply_below_sleep_limit = 1'b0;
      $display("t_ctl done");
   endtask
   task t_prot;
      host.send(2'h3, 16'h0000);
      w(3);
      charge_prot_active = 1'b1;
      host.send(2'h3, 16'h0c00);
      w(3);
      `CHK("chg_held", 1'b1, charge_switch_pin)
      `CHK("dis_pin", 1'b0, discharge_switch_pin)
      charge_prot_active = 1'b0;
      w(2);
      `CHK("chg_free", 1'b0, charge_switch_pin)
      discharge_prot_active = 1'b1;
      host.send(2'h3, 16'h0000);
      w(3);
      `CHK("dis_held", 1'b0, discharge_switch_pin)
      `CHK("chg_off", 1'b1, charge_switch_pin)
      discharge_prot_active = 1'b0;
      w(2);
      `CHK("dis_free", 1'b1, discharge_switch_pin)
      $display("t_prot done");
   endtask
   task t_nv;
      host.send(2'h0, 16'h5a80);
      pwr(2);
      `CHK("cfg_lost", 16'h30c0, config_rdata)
      host.send(2'h0, 16'h5a80);
      host.send(2'h2, 16'h0000);
      w(3);
      `CHK("no_latch", 1'b0, store_busy)
      host.store(16'h1234);
      `CHK("storing", 1'b1, store_busy)
      host.send(2'h3, 16'hf000);
      host.send(2'h0, 16'h0000);
      w(3);
      `CHK("sram", 16'h0000, config_rdata)
      pwr(2);
      `CHK("cfg_kept", 16'h5a80, config_rdata)
      `CHK("ctl_lost", 4'h0, balance_pin)
      $display("t_nv done");
   endtask
   task t_sleep;
      host.send(2'h3, 16'h0080);
      w(3);
      `CHK("no_sleep", 1'b0, sleep_active)
      host.send(2'h3, 16'h3080);
      supply_below_sleep_limit = 1'b1;
      w(3);
      `CHK("asleep", 1'b1, sleep_active)
      `CHK("bal", 4'h3, balance_pin)
      wake_event = 1'b1;
      w(1);
      wake_event = 1'b0;
      supply_below_sleep_limit = 1'b0;
      w(3);
      `CHK("awake", 1'b0, sleep_active)
      `CHK("bal_clr", 4'h0, balance_pin)
      $display("t_sleep done");
   endtask
   initial begin
      srst = 1'b1;
      supply_below_sleep_limit = 1'b0;
      wake_event = 1'b0;
      charge_prot_active = 1'b0;
      discharge_prot_active = 1'b0;
      pwr(16);
      t_boot();
      t_cfg();
      t_ctl();
      t_prot();
      t_nv();
      t_sleep();
      summarize();
   end
endmodule // tb
